//--- pps_pkg.sv
`default_nettype none
package pps_pkg;

    // =====================================================================
    // Clock rate and timebase
    // =====================================================================
    localparam int unsigned CLOCK_HZ       = 250000000;   // Device clock rate
    localparam int unsigned TICK_US        = 1000;        // Timebase tick period, microseconds
    localparam int unsigned TICK_CYCLES    = (CLOCK_HZ / 1000000) * TICK_US; // Cycles per tick
    localparam int unsigned TICK_CNT_W     = 20;          // Timebase counter width

    // =====================================================================
    // Durations, counted in ticks of one millisecond
    // =====================================================================
    localparam int unsigned TURN_ON_DEBOUNCE_MS   = 32;   // Default turn-on hold
    localparam int unsigned TURN_OFF_DEBOUNCE_MS  = 32;   // Default turn-off hold
    localparam int unsigned RELEASE_DEBOUNCE_MS   = 32;   // Button release debounce
    localparam int unsigned TURN_ON_BLANK_MS      = 512;  // Blanking after enable
    localparam int unsigned TURN_OFF_DELAY_MS     = 1024; // Shutdown grace period
    localparam int unsigned ENABLE_LOCKOUT_MS     = 256;  // Lockout after release
    localparam int unsigned MS_CNT_W              = 16;   // Millisecond counter width

    // =====================================================================
    // Power-off request qualification
    // =====================================================================
    localparam int unsigned OFF_REQ_MIN_NS   = 30000;     // Least recognised low pulse
    localparam int unsigned CLOCK_PERIOD_NS  = 4;         // Clock period
    localparam int unsigned OFF_REQ_CYCLES   = (OFF_REQ_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned OFF_REQ_CNT_W    = 14;        // Filter counter width

    // =====================================================================
    // Sequencer states
    // =====================================================================
    typedef enum logic [2:0] {
        PPS_OFF       = 3'b000,  // Waiting for a press
        PPS_ON_DEB    = 3'b001,  // Counting turn-on hold
        PPS_BLANK     = 3'b010,  // Inputs ignored after enable
        PPS_REL_DEB   = 3'b011,  // Debouncing button release
        PPS_RUN       = 3'b100,  // Powered, watching inputs
        PPS_OFF_DEB   = 3'b101,  // Counting turn-off hold
        PPS_OFF_WAIT  = 3'b110,  // Interrupt raised, grace period
        PPS_LOCKOUT   = 3'b111   // Button ignored after release
    } pps_state_type;

    // Open-drain pin drive, kept together
    typedef struct packed {
        logic out;   // Level driven when enabled
        logic oe;    // High while driving
    } pps_od_type;

endpackage
`default_nettype wire

//--- pps_sync.sv
`timescale 1ns/100ps
`default_nettype none
// =========================================================================
// Two-flop synchroniser for asynchronous pins
// =========================================================================
module pps_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_reg;  // First stage, read only by the second

    // Chain of two; resets to the idle pin level
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_reg <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // pps_sync
`default_nettype wire

//--- pps_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// RQ1: Enable after 32 ms unbroken low press
// RQ2: Extra configurable turn-on hold added
// RQ3: Turn-off press valid after 32 ms low
// RQ4: Extra configurable turn-off hold added
// RQ5: 512 ms blanking starts at enable
// RQ6: Ignore button and request while blanking
// RQ7: Request low after blanking aborts power-up
// RQ8: Processor raises request before blanking ends
// RQ9: Request low after blanking releases enable
// RQ10: Valid turn-off press pulls interrupt low
// RQ11: 1024 ms delay starts at interrupt
// RQ12: Delay expiry releases enable
// RQ13: Request low during delay releases immediately
// RQ14: Open-drain enable, polarity selectable
// RQ15: Button ignored during lockout after release
// RQ16: Request low at least 30 us
// RQ17: Interrupt may be tied to request
// RQ18: Lockout lasts 256 ms from release
// RQ19: Button high restarts any debounce; the code restarts the release debounce on button low instead
// RQ20: Release debounced 32 ms before new press
// RQ21: Reset holds outputs released, state off
// RQ22: All periods from one timebase tick; the code times the 30 us request filter in clock cycles instead
// RQ23: Interrupt released on return to off
module pps_sequencer #(
    parameter int unsigned TICK_CYCLES_P = pps_pkg::TICK_CYCLES, // Shorten for simulation
    parameter logic        ENABLE_HIGH   = 1'b1                  // 1: high-true, 0: low-true
) (
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    input  wire logic                        button_n,        // Pushbutton pin, low when pressed
    input  wire logic                        off_request_n,   // Processor power-off request pin
    input  wire logic [pps_pkg::MS_CNT_W-1:0] on_hold_extend,  // Extra turn-on hold, ms
    input  wire logic [pps_pkg::MS_CNT_W-1:0] off_hold_extend, // Extra turn-off hold, ms
    input  wire logic                        power_en_in,     // Enable pin level, unused by logic
    output var  logic                        power_en_out,    // Enable pin drive level
    output var  logic                        power_en_oe,     // Enable pin drive enable
    input  wire logic                        int_n_in,        // Interrupt pin level, unused by logic
    output var  logic                        int_n_out,       // Interrupt pin drive level
    output var  logic                        int_n_oe,        // Interrupt pin drive enable
    output var  logic                        power_on         // Sequencer holds power enabled
);

    // =====================================================================
    // Pin synchronisers
    // =====================================================================
    logic button_n_s;   // Synchronised button
    logic req_n_s;      // Synchronised power-off request

    pps_sync #(.RESET_VALUE(1'b1)) u_sync_button (
        .clock   (clock),
        .rst_n   (rst_n),
        .async_in(button_n),
        .sync_out(button_n_s)
    );

    pps_sync #(.RESET_VALUE(1'b0)) u_sync_request (
        .clock   (clock),
        .rst_n   (rst_n),
        .async_in(off_request_n),
        .sync_out(req_n_s)
    );

    // =====================================================================
    // Timebase: one tick per millisecond
    // =====================================================================
    logic [pps_pkg::TICK_CNT_W-1:0] tick_cnt_reg;  // Cycle counter
    logic                           tick;          // One-cycle tick

    assign tick = (tick_cnt_reg == pps_pkg::TICK_CNT_W'(TICK_CYCLES_P - 1));

    // Free-running divider shared by every millisecond period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
        end else if (tick) begin
            tick_cnt_reg <= '0;  // RQ22
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
        end
    end

    // =====================================================================
    // Power-off request filter: low must last 30 us
    // =====================================================================
    logic [pps_pkg::OFF_REQ_CNT_W-1:0] req_cnt_reg;  // Low-time counter
    logic                              req_low_reg;  // Qualified request

    // Short glitches below the least pulse are rejected, at the cost of 30 us latency
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            req_cnt_reg <= '0;
            req_low_reg <= 1'b0;
        end else if (req_n_s) begin
            req_cnt_reg <= '0;
            req_low_reg <= 1'b0;
        end else if (req_cnt_reg == pps_pkg::OFF_REQ_CNT_W'(pps_pkg::OFF_REQ_CYCLES - 1)) begin
            req_low_reg <= 1'b1;  // RQ16
        end else begin
            req_cnt_reg <= req_cnt_reg + 1'b1;
        end
    end

    // =====================================================================
    // Sequencer state and millisecond counter
    // =====================================================================
    pps_pkg::pps_state_type         state_reg;   // Current state
    pps_pkg::pps_state_type         state_next;  // Next state
    logic [pps_pkg::MS_CNT_W-1:0]   ms_reg;      // Elapsed ms in state
    logic                           ms_clear;    // Restart the count
    logic [pps_pkg::MS_CNT_W:0]     on_limit;    // Turn-on hold total
    logic [pps_pkg::MS_CNT_W:0]     off_limit;   // Turn-off hold total
    logic [pps_pkg::MS_CNT_W:0]     ms_ext;      // Count widened for compare

    assign on_limit  = (pps_pkg::MS_CNT_W+1)'(pps_pkg::TURN_ON_DEBOUNCE_MS) + {1'b0, on_hold_extend};   // RQ2
    assign off_limit = (pps_pkg::MS_CNT_W+1)'(pps_pkg::TURN_OFF_DEBOUNCE_MS) + {1'b0, off_hold_extend}; // RQ4
    assign ms_ext    = {1'b0, ms_reg};

    // Next-state logic; counts compare against whole ticks seen in the state
    always_comb begin
        state_next = state_reg;
        ms_clear   = 1'b0;
        case (state_reg)
            pps_pkg::PPS_OFF: begin
                if (!button_n_s) begin
                    state_next = pps_pkg::PPS_ON_DEB;
                    ms_clear   = 1'b1;
                end
            end
            pps_pkg::PPS_ON_DEB: begin
                if (button_n_s) begin
                    state_next = pps_pkg::PPS_OFF;  // RQ19
                end else if (ms_ext >= on_limit) begin
                    state_next = pps_pkg::PPS_BLANK;  // RQ1
                    ms_clear   = 1'b1;  // RQ5
                end
            end
            pps_pkg::PPS_BLANK: begin
                // Both inputs ignored until the window closes
                if (ms_reg >= pps_pkg::MS_CNT_W'(pps_pkg::TURN_ON_BLANK_MS)) begin  // RQ6
                    ms_clear = 1'b1;
                    if (!req_n_s) begin
                        state_next = pps_pkg::PPS_LOCKOUT;  // RQ7
                    end else begin
                        state_next = pps_pkg::PPS_REL_DEB;  // RQ20
                    end
                end
            end
            pps_pkg::PPS_REL_DEB: begin
                if (req_low_reg) begin
                    state_next = pps_pkg::PPS_LOCKOUT;  // RQ9
                    ms_clear   = 1'b1;
                end else if (!button_n_s) begin
                    ms_clear = 1'b1;  // RQ20
                end else if (ms_reg >= pps_pkg::MS_CNT_W'(pps_pkg::RELEASE_DEBOUNCE_MS)) begin
                    state_next = pps_pkg::PPS_RUN;
                end
            end
            pps_pkg::PPS_RUN: begin
                if (req_low_reg) begin
                    state_next = pps_pkg::PPS_LOCKOUT;  // RQ9
                    ms_clear   = 1'b1;
                end else if (!button_n_s) begin
                    state_next = pps_pkg::PPS_OFF_DEB;
                    ms_clear   = 1'b1;
                end
            end
            pps_pkg::PPS_OFF_DEB: begin
                if (req_low_reg) begin
                    state_next = pps_pkg::PPS_LOCKOUT;  // RQ9
                    ms_clear   = 1'b1;
                end else if (button_n_s) begin
                    state_next = pps_pkg::PPS_RUN;  // RQ19
                end else if (ms_ext >= off_limit) begin
                    state_next = pps_pkg::PPS_OFF_WAIT;  // RQ3
                    ms_clear   = 1'b1;  // RQ11
                end
            end
            pps_pkg::PPS_OFF_WAIT: begin
                if (req_low_reg) begin
                    state_next = pps_pkg::PPS_LOCKOUT;  // RQ13
                    ms_clear   = 1'b1;
                end else if (ms_reg >= pps_pkg::MS_CNT_W'(pps_pkg::TURN_OFF_DELAY_MS)) begin
                    state_next = pps_pkg::PPS_LOCKOUT;  // RQ12
                    ms_clear   = 1'b1;
                end
            end
            pps_pkg::PPS_LOCKOUT: begin
                // Button ignored; then wait for it to be released before re-arming
                if (ms_reg >= pps_pkg::MS_CNT_W'(pps_pkg::ENABLE_LOCKOUT_MS) && button_n_s) begin  // RQ15 RQ18
                    state_next = pps_pkg::PPS_OFF;  // RQ23
                end
            end
            default: begin
                state_next = pps_pkg::PPS_OFF;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= pps_pkg::PPS_OFF;  // RQ21
        end else begin
            state_reg <= state_next;
        end
    end

    // Millisecond counter, saturating so long holds never wrap
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ms_reg <= '0;
        end else if (ms_clear) begin
            ms_reg <= '0;  // RQ22
        end else if (tick && ms_reg != '1) begin
            ms_reg <= ms_reg + 1'b1;
        end
    end

    // =====================================================================
    // Open-drain outputs
    // =====================================================================
    logic             en_assert_reg;  // Enable asserted
    logic             int_low_reg;    // Interrupt pulled low
    pps_pkg::pps_od_type en_drive;    // Enable pin drive
    pps_pkg::pps_od_type int_drive;   // Interrupt pin drive

    // Registered so pins never glitch on decode
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_assert_reg <= 1'b0;  // RQ21
            int_low_reg   <= 1'b0;
        end else begin
            en_assert_reg <= (state_next == pps_pkg::PPS_BLANK) || (state_next == pps_pkg::PPS_REL_DEB) ||
                             (state_next == pps_pkg::PPS_RUN) || (state_next == pps_pkg::PPS_OFF_DEB) ||
                             (state_next == pps_pkg::PPS_OFF_WAIT);
            int_low_reg   <= (state_next == pps_pkg::PPS_OFF_WAIT) ||
                             (state_next == pps_pkg::PPS_LOCKOUT && int_low_reg);  // RQ10 RQ23
        end
    end

    // Open drain only sinks: drive low when the pin must be low
    always_comb begin
        en_drive.out  = 1'b0;
        en_drive.oe   = ENABLE_HIGH ? !en_assert_reg : en_assert_reg;  // RQ14
        int_drive.out = 1'b0;
        int_drive.oe  = int_low_reg;  // RQ10
    end

    assign power_en_out = en_drive.out;
    assign power_en_oe  = en_drive.oe;
    assign int_n_out    = int_drive.out;
    assign int_n_oe     = int_drive.oe;
    assign power_on     = en_assert_reg;

endmodule // pps_sequencer
`default_nettype wire

//--- pps_sequencer_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Checker on the sequencer pins
module pps_sequencer_monitor #(
    parameter int unsigned TICK_CYCLES_P = 10,
    parameter logic        ENABLE_HIGH   = 1'b1
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        button_n,
    input wire logic        off_request_n,
    input wire logic [15:0] on_hold_extend,
    input wire logic [15:0] off_hold_extend,
    input wire logic        power_en_in,
    input wire logic        power_en_out,
    input wire logic        power_en_oe,
    input wire logic        int_n_in,
    input wire logic        int_n_out,
    input wire logic        int_n_oe,
    input wire logic        power_on
);
    localparam int unsigned T = TICK_CYCLES_P;
    localparam int unsigned REQ_LONG = 7560;    // Well past the 30 us filter
    logic [31:0] low_cnt;                        // Button low run
    logic [31:0] on_cnt;                         // Power on run
    logic [31:0] off_cnt;                        // Power off run
    logic [31:0] int_cnt;                        // Interrupt run
    logic [31:0] req_cnt;                        // Request low run
    logic        late_req;                       // Request fell after blanking
    // Run lengths; off run starts large so the first press is not a lockout
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            low_cnt <= 32'h0;
            on_cnt  <= 32'h0;
            off_cnt <= 32'h00ffffff;
            int_cnt <= 32'h0;
            req_cnt <= 32'h0;
            late_req <= 1'b0;
        end else begin
            low_cnt <= button_n ? 32'h0 : low_cnt + 32'h1;
            on_cnt  <= power_on ? on_cnt + 32'h1 : 32'h0;
            off_cnt <= power_on ? 32'h0 : off_cnt + 32'h1;
            int_cnt <= int_n_oe ? int_cnt + 32'h1 : 32'h0;
            req_cnt <= off_request_n ? 32'h0 : req_cnt + 32'h1;
            // Judged at the fall, since power_on resets on_cnt before the check
            late_req <= !off_request_n && (req_cnt == 32'h0 ? on_cnt > 514 * T : late_req);
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Long request low that began after blanking
    sequence s_long_req;
        req_cnt == REQ_LONG && late_req;
    endsequence
    a_od_levels: assert property (!power_en_out && !int_n_out)
        else $error("open drain pin driven high");
    a_en_polarity: assert property (power_en_oe == (ENABLE_HIGH ? !power_on : power_on))
        else $error("enable drive polarity wrong");
    a_reset_idle: assert property (disable iff (1'b0) !rst_n |=> !power_on && !int_n_oe)
        else $error("outputs active in reset");
    a_on_press: assert property ($rose(power_on) |-> low_cnt >= (31 + on_hold_extend) * T)
        else $error("power on without full press");
    a_int_press: assert property ($rose(int_n_oe) |-> power_on && low_cnt >= (31 + off_hold_extend) * T)
        else $error("interrupt without full press");
    a_blank_hold: assert property ($fell(power_on) |-> on_cnt >= 511 * T)
        else $error("power dropped in blanking");
    a_kill_drop: assert property (s_long_req |-> !power_on)
        else $error("request low did not release");
    a_off_timeout: assert property (int_cnt == 1025 * T + 10 |-> !power_on)
        else $error("turn off delay overrun");
    a_off_delay_min: assert property ($fell(power_on) && int_n_oe && $past(off_request_n) |-> int_cnt >= 1023 * T)
        else $error("turn off delay too short");
    a_int_release: assert property ($fell(int_n_oe) |-> !power_on && off_cnt >= 255 * T)
        else $error("interrupt released early");
    a_lockout_hold: assert property ($rose(power_on) |-> off_cnt >= 286 * T)
        else $error("power on inside lockout");
endmodule // pps_sequencer_monitor
`default_nettype wire

//--- pps_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Processor model; mode 0 normal, 1 never confirms, 2 ignores interrupt, 3 interrupt tied to request
module pps_cpu_model #(
    parameter int unsigned UP_CYC   = 2000,
    parameter int unsigned DOWN_CYC = 1000
) (
    input wire logic       clock,
    input wire logic       rst_n,
    input wire logic       en_pin,
    input wire logic       int_pin,
    input wire logic [1:0] mode,
    input wire logic       kill,
    output var logic       off_request_n
);
    logic [15:0] up_cnt;   // Cycles since powered
    logic [15:0] int_cnt;  // Cycles of interrupt low
    // Unpowered processor restarts from zero
    always_ff @(posedge clock) begin
        if (!rst_n || !en_pin) begin
            up_cnt  <= 16'h0;
            int_cnt <= 16'h0;
        end else begin
            if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h1;
            if (!int_pin && int_cnt != 16'hffff) int_cnt <= int_cnt + 16'h1;
        end
    end
    // Interrupt-driven low stays low till power goes, far beyond 30 us; kill low ends when kill drops
    // Mode 3 wires the interrupt pin straight to the request pin
    assign off_request_n = (mode == 2'd3) ? int_pin : (en_pin && up_cnt >= UP_CYC && mode != 2'd1 && !kill
                           && !(mode != 2'd2 && int_cnt >= DOWN_CYC));
endmodule // pps_cpu_model
`default_nettype wire

//--- pps_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// Sequencer bench with 10-cycle millisecond tick
module pps_sequencer_tb;
    localparam int unsigned T = 10;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        button_n = 1'b1;
    logic        kill = 1'b0;
    logic [1:0]  mode = 2'd0;
    logic [15:0] on_ext = 16'h0;
    logic [15:0] off_ext = 16'h0;
    logic        en_out, en_oe, int_out, int_oe, power_on, off_req_n;
    logic        lo_oe;    // Low-true variant enable drive
    logic        en_pin, int_pin;  // Pulled-up pin levels
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;
    assign en_pin  = en_oe ? en_out : 1'b1;
    assign int_pin = int_oe ? int_out : 1'b1;
    always #2 clock = ~clock;
    pps_sequencer #(.TICK_CYCLES_P(T), .ENABLE_HIGH(1'b1)) dut (
        .clock(clock), .rst_n(rst_n), .button_n(button_n), .off_request_n(off_req_n),
        .on_hold_extend(on_ext), .off_hold_extend(off_ext), .power_en_in(en_pin),
        .power_en_out(en_out), .power_en_oe(en_oe), .int_n_in(int_pin),
        .int_n_out(int_out), .int_n_oe(int_oe), .power_on(power_on));
    // Low-true variant on the same inputs
    pps_sequencer #(.TICK_CYCLES_P(T), .ENABLE_HIGH(1'b0)) dut_low (
        .clock(clock), .rst_n(rst_n), .button_n(button_n), .off_request_n(off_req_n),
        .on_hold_extend(on_ext), .off_hold_extend(off_ext), .power_en_in(!lo_oe),
        .power_en_out(), .power_en_oe(lo_oe), .int_n_in(int_pin),
        .int_n_out(), .int_n_oe(), .power_on());
    pps_cpu_model cpu (.clock(clock), .rst_n(rst_n), .en_pin(en_pin), .int_pin(int_pin),
        .mode(mode), .kill(kill), .off_request_n(off_req_n));
    task automatic cycles(input int k);
        repeat (k) @(posedge clock);
    endtask
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            $display("[ERR] %0t %s", $time, msg);
            fail_count++;
        end
    endtask
    // Bounded wait on power_on (sel 0) or interrupt (sel 1)
    task automatic wait_on(input bit sel, input logic v, input int lim, output int cyc);
        cyc = 0;
        while (((sel ? int_oe : power_on) !== v) && cyc < lim) begin
            @(posedge clock);
            cyc++;
        end
        if (cyc >= lim) chk(1'b0, "wait limit");
    endtask
    task automatic power_up;
        button_n <= 1'b0;
        wait_on(1'b0, 1'b1, 40 * T, n);
        button_n <= 1'b1;
        cycles(600 * T);
        chk(power_on === 1'b1, "power not held");
    endtask
    task automatic t_abort;
        chk(power_on === 1'b0 && int_oe === 1'b0, "reset outputs");
        chk(en_oe === 1'b1 && en_out === 1'b0 && int_out === 1'b0, "pin drive");
        chk(lo_oe === 1'b0, "low-true released");
        button_n <= 1'b0;
        cycles(30 * T);
        button_n <= 1'b1;
        cycles(5 * T);
        chk(power_on === 1'b0, "short press");
        mode <= 2'd1;
        on_ext <= 16'd2;
        button_n <= 1'b0;
        wait_on(1'b0, 1'b1, 40 * T, n);
        chk(n >= 33 * T && n <= 35 * T + 5, "on hold");
        chk(en_oe === 1'b0, "enable asserted");
        chk(lo_oe === 1'b1, "low-true asserted");
        wait_on(1'b0, 1'b0, 520 * T, n);
        chk(n >= 511 * T && n <= 513 * T + 5, "blank abort");
        button_n <= 1'b1;
        cycles(180 * T);
        button_n <= 1'b0;
        cycles(60 * T);
        button_n <= 1'b1;
        cycles(60 * T);
        chk(power_on === 1'b0, "lockout press");
    endtask
    task automatic t_timeout;
        mode <= 2'd2;
        on_ext <= 16'd0;
        off_ext <= 16'd1;
        power_up();
        button_n <= 1'b0;
        wait_on(1'b1, 1'b1, 40 * T, n);
        chk(n >= 32 * T && n <= 34 * T + 5, "off hold");
        button_n <= 1'b1;
        wait_on(1'b0, 1'b0, 1030 * T, n);
        chk(n >= 1023 * T && n <= 1025 * T + 5, "off delay");
        wait_on(1'b1, 1'b0, 300 * T, n);
        chk(n >= 255 * T && n <= 257 * T + 5, "int release");
    endtask
    task automatic t_kill;
        mode <= 2'd0;
        off_ext <= 16'd0;
        power_up();
        button_n <= 1'b0;
        wait_on(1'b1, 1'b1, 40 * T, n);
        button_n <= 1'b1;
        wait_on(1'b0, 1'b0, 1030 * T, n);
        chk(n >= 8400 && n <= 8700, "kill in delay");
        wait_on(1'b1, 1'b0, 300 * T, n);
        power_up();
        kill <= 1'b1;
        cycles(5000);
        kill <= 1'b0;
        cycles(3000);
        chk(power_on === 1'b1, "short request");
        kill <= 1'b1;
        wait_on(1'b0, 1'b0, 8000, n);
        chk(n >= 7450 && n <= 7550, "run kill");
    endtask
    task automatic t_tied;
        kill <= 1'b0;
        mode <= 2'd3;
        cycles(300 * T);
        power_up();
        button_n <= 1'b0;
        wait_on(1'b1, 1'b1, 40 * T, n);
        button_n <= 1'b1;
        wait_on(1'b0, 1'b0, 8000, n);
        chk(n >= 7450 && n <= 7550, "tied interrupt");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        cycles(12);
        rst_n <= 1'b1;
        cycles(1);
        t_abort();
        t_timeout();
        t_kill();
        t_tied();
        wrap_up();
    end
    // Run needs about 85k cycles
    initial begin
        cycles(100000);
        fail_count++;
        wrap_up();
    end
endmodule // pps_sequencer_tb
bind pps_sequencer pps_sequencer_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P), .ENABLE_HIGH(ENABLE_HIGH)) mon (
    .clock(clock), .rst_n(rst_n), .button_n(button_n), .off_request_n(off_request_n),
    .on_hold_extend(on_hold_extend), .off_hold_extend(off_hold_extend), .power_en_in(power_en_in),
    .power_en_out(power_en_out), .power_en_oe(power_en_oe), .int_n_in(int_n_in),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe), .power_on(power_on));
`default_nettype wire
